/* src/mbrsm_pkg.sv */
// mbrsm_pkg: constants and carrier types of the scan master.
// assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
package mbrsm_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int T10MS_NS = 10_000_000;
  localparam int T10MS_CYC = T10MS_NS / CLK_NS;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_TIM = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_RXC = 8'h10;
  localparam logic [7:0] A_TXC = 8'h14;
  localparam logic [7:0] A_NODE = 8'h40;
  localparam logic [7:0] A_FRM = 8'h80;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_DV_BIT = 13;
  localparam int CFG_CS_LO = 0;
  localparam int CFG_RESTART = 2;
  localparam int CFG_STATS = 3;
  localparam int CFG_RATE_LO = 4;
  localparam int CFG_D8 = 7;
  localparam int CFG_PAR_LO = 8;
  localparam int CFG_STOP2 = 10;
  localparam int CFG_PHY_LO = 11;
  localparam int TIM_DLM_LO = 0;
  localparam int TIM_TMO_LO = 8;
  localparam int TIM_RTY_LO = 16;
  localparam int TIM_BC_LO = 24;
  localparam int NODE_LEN_LO = 8;
  localparam int NODE_EN = 12;
  localparam int ST_RUN = 0;
  localparam int ST_FATAL = 1;
  localparam int ST_NI_LO = 4;
  localparam int ST_DISC_LO = 8;
  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [31:0] CFG_RST = 32'h000010b9;
  localparam logic [31:0] TIM_RST = 32'h01030a00;
  localparam logic [1:0] CS_OFF = 2'h0;
  localparam logic [1:0] CS_ON = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PHY_232 = 2'h0;
  localparam logic [1:0] PHY_422 = 2'h1;
  localparam logic [1:0] PHY_485 = 2'h2;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mbrsm_avs_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } mbrsm_avs_rsp_t;
  typedef struct packed {
    logic rxd232;
    logic rxd422;
    logic rxd485;
  } mbrsm_sub_in_t;
  typedef struct packed {
    logic txd232;
    logic txd422;
    logic txd485;
    logic de485;
  } mbrsm_sub_out_t;
endpackage

/* src/mbrsm_scan_master.sv */
// mbrsm_scan_master: Modbus RTU scan-list master with serial port.
// assumes synchronous inputs, one clock, Avalon-MM master on avs_i.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mbrsm_scan_master #(
  parameter int NODES = 8,
  parameter int MAXB = 8,
  parameter int T10_CYC = mbrsm_pkg::T10MS_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire mbrsm_pkg::mbrsm_avs_req_t avs_i,
  output mbrsm_pkg::mbrsm_avs_rsp_t avs_o,
  input wire mbrsm_pkg::mbrsm_sub_in_t sub_i,
  output mbrsm_pkg::mbrsm_sub_out_t sub_o,
  output logic fatal_o
);
  import mbrsm_pkg::*;

  localparam int IW = $clog2(NODES);
  localparam int BW = $clog2(MAXB);
  localparam int NW = NODES * MAXB / 4;

  typedef enum logic [2:0] {S_IDLE, S_GAP, S_TXB, S_WAIT, S_BCAST, S_HALT} mbrsm_st_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] tim;
    logic [NODES-1:0][12:0] node;
    logic [NODES*MAXB-1:0][7:0] frm;
    logic [15:0] rxc;
    logic [15:0] txc;
    logic [NODES-1:0] disc;
    logic fatal;
    mbrsm_st_t st;
    logic [IW-1:0] ni;
    logic [3:0] bi;
    logic [15:0] tcrc;
    logic [11:0] sh;
    logic [3:0] nb;
    logic [15:0] bc;
    logic [31:0] tmr;
    logic [7:0] rtry;
    logic rbusy;
    logic [15:0] rbc;
    logic [3:0] rpos;
    logic [11:0] rsh;
    logic [15:0] rcrc;
    logic [7:0] rcnt;
    logic [7:0] rfirst;
    logic rerr;
    logic [7:0] ridle;
    logic ack;
    logic [31:0] rd;
  } mbrsm_state_t;

  mbrsm_state_t s_q, s_d;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int r;
    unique case (sel)
      3'h0: r = 1200;
      3'h1: r = 2400;
      3'h2: r = 4800;
      3'h3: r = 9600;
      3'h4: r = 19200;
      3'h5: r = 38400;
      default: r = 57600;
    endcase
    return 16'(CLK_HZ / r);
  endfunction

  function automatic logic [3:0] nbits(input logic [31:0] c);
    return 4'(1 + (c[CFG_D8] ? 8 : 7) + (c[CFG_PAR_LO +: 2] != PAR_NONE ? 1 : 0)
      + (c[CFG_STOP2] ? 2 : 1));
  endfunction

  // lsb-first character image: start, data, parity, stop(s)
  function automatic logic [11:0] mkchar(input logic [7:0] d, input logic [31:0] c);
    logic [11:0] v;
    logic p;
    int k;
    v = 12'hfff;
    v[0] = 1'b0;
    p = c[CFG_D8] ? ^d : ^d[6:0];
    for (k = 0; k < 8; k++) begin
      if (k < 7 || c[CFG_D8]) begin
        v[k+1] = d[k];
      end
    end
    k = c[CFG_D8] ? 9 : 8;
    if (c[CFG_PAR_LO +: 2] != PAR_NONE) begin
      v[k] = (c[CFG_PAR_LO +: 2] == PAR_ODD) ? ~p : p;
    end
    return v;
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // idle of 3.5 characters, in bit times
  function automatic logic [7:0] t35(input logic [31:0] c);
    return 8'((7 * nbits(c) + 1) / 2);
  endfunction

  function automatic logic [31:0] gap(input mbrsm_state_t s);
    if (s.tim[TIM_DLM_LO +: 8] == 8'h00) begin
      return 32'(t35(s.cfg)) * 32'(baud_div(s.cfg[CFG_RATE_LO +: 3]));
    end
    return 32'(s.tim[TIM_DLM_LO +: 8]) * 32'(T10_CYC);
  endfunction

  // byte k of the current frame: address, stored bytes, crc lo, crc hi
  function automatic logic [7:0] txbyte(input mbrsm_state_t s, input logic [3:0] k);
    logic [3:0] len;
    len = s.node[s.ni][NODE_LEN_LO +: 4];
    if (k == 4'h0) begin
      return s.node[s.ni][7:0];
    end
    if (k <= len) begin
      return s.frm[{s.ni, BW'(k - 4'h1)}];
    end
    return (k == len + 4'h1) ? s.tcrc[7:0] : s.tcrc[15:8];
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int j = 0; j < 4; j++) begin
      if (be[j]) begin
        r[8*j +: 8] = w[8*j +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] cs;
    logic go;
    logic rxd;
    logic adv;
    logic rend;
    logic valid;
    logic [15:0] div;
    logic [3:0] len;
    logic [7:0] b;
    logic [11:0] chr;
    logic [11:0] msk;
    logic [7:0] d7;
    logic [7:0] a;
    int w;
    s_d = s_q;
    cs = s_q.cfg[CFG_CS_LO +: 2];
    go = (cs != CS_ON) || s_q.ctrl[CTRL_DV_BIT];
    div = baud_div(s_q.cfg[CFG_RATE_LO +: 3]);
    len = s_q.node[s_q.ni][NODE_LEN_LO +: 4];
    adv = 1'b0;
    b = 8'h00;
    chr = s_q.rsh;
    msk = ~(12'hfff << nbits(s_q.cfg));
    d7 = 8'h00;
    a = avs_i.address;
    w = 0;
    unique case (s_q.cfg[CFG_PHY_LO +: 2])
      PHY_232: rxd = sub_i.rxd232;
      PHY_422: rxd = sub_i.rxd422;
      default: rxd = sub_i.rxd485;
    endcase

    // receiver, idle while our own frame is on the line
    rend = !s_q.rbusy && s_q.rcnt != 8'h00 && s_q.ridle >= t35(s_q.cfg);
    valid = !s_q.rerr && s_q.rcnt >= 8'h04 && s_q.rcrc == 16'h0000;
    if (rend) begin
      s_d.rcnt = 8'h00;
      s_d.rerr = 1'b0;
      s_d.rcrc = CRC_INIT;
      if (valid && s_q.cfg[CFG_STATS]) begin
        s_d.rxc = s_q.rxc + 16'h0001;
      end
    end
    if (s_q.rbusy) begin
      if (s_q.rbc == 16'h0000) begin
        chr[s_q.rpos] = rxd;
        s_d.rsh = chr;
        s_d.rbc = div - 16'h0001;
        s_d.rpos = s_q.rpos + 4'h1;
        if (s_q.rpos == nbits(s_q.cfg) - 4'h1) begin
          s_d.rbusy = 1'b0;
          d7 = s_q.cfg[CFG_D8] ? chr[8:1] : {1'b0, chr[7:1]};
          if ((chr & msk) != (mkchar(d7, s_q.cfg) & msk)) begin
            s_d.rerr = 1'b1;
          end
          s_d.rcrc = crc_upd(s_d.rcrc, d7);
          s_d.rcnt = s_d.rcnt + 8'h01;
          if (s_d.rcnt == 8'h01) begin
            s_d.rfirst = d7;
          end
        end
      end else begin
        s_d.rbc = s_q.rbc - 16'h0001;
      end
    end else if (!rxd && s_q.st != S_TXB) begin
      s_d.rbusy = 1'b1;
      s_d.rpos = 4'h0;
      s_d.rbc = div >> 1;
      s_d.ridle = 8'h00;
    end else if (s_q.rbc == 16'h0000) begin
      s_d.rbc = div - 16'h0001;
      if (s_q.ridle != 8'hff) begin
        s_d.ridle = s_q.ridle + 8'h01;
      end
    end else begin
      s_d.rbc = s_q.rbc - 16'h0001;
    end

    // scan engine, master only
    unique case (s_q.st)
      S_IDLE: begin
        if (go) begin
          if (!s_q.node[s_q.ni][NODE_EN]) begin
            adv = 1'b1;
          end else if (len == 4'h0 || len > 4'(MAXB)) begin
            if (s_q.cfg[CFG_RESTART]) begin
              s_d.ni = '0;
              s_d.disc = '0;
              s_d.rtry = 8'h00;
            end else begin
              s_d.fatal = 1'b1;
              s_d.st = S_HALT;
            end
          end else begin
            s_d.st = S_GAP;
            s_d.tmr = gap(s_q);
            s_d.bi = 4'h0;
            s_d.tcrc = CRC_INIT;
          end
        end
      end
      S_GAP: begin
        if (s_q.tmr == 32'h0) begin
          b = txbyte(s_q, 4'h0);
          s_d.sh = mkchar(b, s_q.cfg);
          s_d.nb = nbits(s_q.cfg);
          s_d.bc = div - 16'h0001;
          s_d.tcrc = crc_upd(CRC_INIT, b);
          s_d.st = S_TXB;
        end else begin
          s_d.tmr = s_q.tmr - 32'h1;
        end
      end
      S_TXB: begin
        if (s_q.bc != 16'h0000) begin
          s_d.bc = s_q.bc - 16'h0001;
        end else if (s_q.nb != 4'h1) begin
          s_d.bc = div - 16'h0001;
          s_d.sh = s_q.sh >> 1;
          s_d.nb = s_q.nb - 4'h1;
        end else if (s_q.bi == len + 4'h2) begin
          if (s_q.cfg[CFG_STATS]) begin
            s_d.txc = s_q.txc + 16'h0001;
          end
          if (s_q.node[s_q.ni][7:0] == 8'h00) begin
            s_d.st = S_BCAST;
            s_d.tmr = 32'(s_q.tim[TIM_BC_LO +: 8]) * 32'(T10_CYC);
          end else begin
            s_d.st = S_WAIT;
            s_d.tmr = 32'(s_q.tim[TIM_TMO_LO +: 8]) * 32'(T10_CYC);
          end
        end else begin
          b = txbyte(s_q, s_q.bi + 4'h1);
          s_d.bi = s_q.bi + 4'h1;
          s_d.sh = mkchar(b, s_q.cfg);
          s_d.nb = nbits(s_q.cfg);
          s_d.bc = div - 16'h0001;
          if (s_q.bi < len) begin
            s_d.tcrc = crc_upd(s_q.tcrc, b);
          end
        end
      end
      S_WAIT: begin
        if (rend && valid && s_q.rfirst == s_q.node[s_q.ni][7:0]) begin
          s_d.disc[s_q.ni] = 1'b0;
          adv = 1'b1;
        end else if (s_q.tmr == 32'h0) begin
          if (s_q.rtry >= s_q.tim[TIM_RTY_LO +: 8]) begin
            s_d.disc[s_q.ni] = 1'b1;
            adv = 1'b1;
          end else begin
            s_d.rtry = s_q.rtry + 8'h01;
            s_d.st = S_GAP;
            s_d.tmr = gap(s_q);
          end
        end else begin
          s_d.tmr = s_q.tmr - 32'h1;
        end
      end
      S_BCAST: begin
        if (s_q.tmr == 32'h0) begin
          adv = 1'b1;
        end else begin
          s_d.tmr = s_q.tmr - 32'h1;
        end
      end
      S_HALT: begin
        s_d.st = S_HALT;
      end
    endcase
    if (adv) begin
      s_d.ni = s_q.ni + 1'b1;
      s_d.rtry = 8'h00;
      s_d.st = S_IDLE;
    end

    // bus slave: one wait state, write lands on the releasing edge
    s_d.ack = (avs_i.read || avs_i.write) && !s_q.ack;
    if (a >= A_FRM && a < A_FRM + 8'(4 * NW)) begin
      w = int'((a - A_FRM) >> 2);
    end
    if (avs_i.read && !s_q.ack) begin
      s_d.rd = 32'h0;
      if (a == A_CTRL && cs != CS_OFF) begin
        s_d.rd = s_q.ctrl;
      end else if (a == A_CFG) begin
        s_d.rd = s_q.cfg;
      end else if (a == A_TIM) begin
        s_d.rd = s_q.tim;
      end else if (a == A_STAT && cs != CS_OFF) begin
        s_d.rd[ST_RUN] = go && s_q.st != S_HALT;
        s_d.rd[ST_FATAL] = s_q.fatal;
        s_d.rd[ST_NI_LO +: IW] = s_q.ni;
        s_d.rd[ST_DISC_LO +: NODES] = s_q.disc;
      end else if (a == A_RXC) begin
        s_d.rd = {16'h0000, s_q.rxc};
      end else if (a == A_TXC) begin
        s_d.rd = {16'h0000, s_q.txc};
      end else if (a >= A_NODE && a < A_NODE + 8'(4 * NODES)) begin
        s_d.rd = {19'h0, s_q.node[IW'((a - A_NODE) >> 2)]};
      end else if (a >= A_FRM && a < A_FRM + 8'(4 * NW)) begin
        s_d.rd = {s_q.frm[4*w+3], s_q.frm[4*w+2], s_q.frm[4*w+1], s_q.frm[4*w]};
      end
    end
    if (avs_i.write && s_q.ack) begin
      if (a == A_CTRL && cs != CS_OFF) begin
        s_d.ctrl = be_merge(s_q.ctrl, avs_i.writedata, avs_i.byteenable);
      end else if (a == A_CFG) begin
        s_d.cfg = be_merge(s_q.cfg, avs_i.writedata, avs_i.byteenable);
      end else if (a == A_TIM) begin
        s_d.tim = be_merge(s_q.tim, avs_i.writedata, avs_i.byteenable);
      end else if (a >= A_NODE && a < A_NODE + 8'(4 * NODES)) begin
        s_d.node[IW'((a - A_NODE) >> 2)] = 13'(be_merge(
          {19'h0, s_q.node[IW'((a - A_NODE) >> 2)]}, avs_i.writedata, avs_i.byteenable));
      end else if (a >= A_FRM && a < A_FRM + 8'(4 * NW)) begin
        for (int j = 0; j < 4; j++) begin
          if (avs_i.byteenable[j]) begin
            s_d.frm[4*w+j] = avs_i.writedata[8*j +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.cfg <= CFG_RST;
      s_q.tim <= TIM_RST;
      s_q.tcrc <= CRC_INIT;
      s_q.rcrc <= CRC_INIT;
      s_q.ridle <= 8'hff;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic line;
  assign line = (s_q.st == S_TXB) ? s_q.sh[0] : 1'b1;
  assign avs_o.readdata = s_q.rd;
  assign avs_o.waitrequest = (avs_i.read || avs_i.write) && !s_q.ack;
  assign sub_o.txd232 = (s_q.cfg[CFG_PHY_LO +: 2] == PHY_232) ? line : 1'b1;
  assign sub_o.txd422 = (s_q.cfg[CFG_PHY_LO +: 2] == PHY_422) ? line : 1'b1;
  assign sub_o.txd485 = (s_q.cfg[CFG_PHY_LO +: 2] == PHY_485) ? line : 1'b1;
  assign sub_o.de485 = (s_q.cfg[CFG_PHY_LO +: 2] == PHY_485) && s_q.st == S_TXB;
  assign fatal_o = s_q.fatal;
endmodule
`default_nettype wire

/* verif/mbrsm_scan_checker.sv */
// mbrsm_scan_checker: port-level assertions for the scan master.
// assumes it is bound onto mbrsm_scan_master and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mbrsm_scan_checker #(
  parameter int NODES = 8,
  parameter int MAXB = 8,
  parameter int T10_CYC = 500
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire mbrsm_pkg::mbrsm_avs_req_t avs_i,
  input wire mbrsm_pkg::mbrsm_avs_rsp_t avs_o,
  input wire mbrsm_pkg::mbrsm_sub_in_t sub_i,
  input wire mbrsm_pkg::mbrsm_sub_out_t sub_o,
  input wire logic fatal_o
);
  import mbrsm_pkg::*;
  logic req;
  assign req = avs_i.read | avs_i.write;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  sequence s_new_req;
    req && !$past(req);
  endsequence
  sequence s_one_wait;
    avs_o.waitrequest ##1 !avs_o.waitrequest;
  endsequence
  property p_one_wait;
    s_new_req |-> s_one_wait;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  property p_idle;
    !req |-> !avs_o.waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  property p_unmapped;
    avs_i.read && !avs_o.waitrequest && avs_i.address > A_TXC && avs_i.address < A_NODE
      |-> avs_o.readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_stand;
    $changed(avs_o.readdata) |-> avs_i.read && !avs_o.waitrequest;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("readdata moved outside a read");
  // ----------------------------------------
  // serial lines and fatal state
  // ----------------------------------------
  property p_unsel;
    sub_o.de485 |-> sub_o.txd232 && sub_o.txd422;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected line active");
  property p_de_gate;
    !sub_o.de485 |-> sub_o.txd485;
  endproperty
  a_de_gate: assert property (p_de_gate) else $error("two-wire data without enable");
  property p_start;
    $fell(sub_o.txd485) |-> !sub_o.txd485 [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_fatal_hold;
    fatal_o |=> fatal_o;
  endproperty
  a_fatal_hold: assert property (p_fatal_hold) else $error("fatal flag dropped");
  property p_halt_quiet;
    fatal_o |-> sub_o.txd485 && !sub_o.de485;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("traffic while halted");
  c_fatal: cover property ($rose(fatal_o));
endmodule
`default_nettype wire

/* verif/mbrsm_slave_model.sv */
// mbrsm_slave_model: behavioural RTU slave on the two-wire line, 8N1.
// assumes line_i is the resolved bus level; idle bias holds it high.
`timescale 1ns/1ps
`default_nettype none
module mbrsm_slave_model #(
  parameter int BIT_CYC = 868,
  parameter logic [7:0] SLV_ADDR = 8'h05,
  parameter int QLEN = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic line_i,
  output logic line_o,
  output logic [31:0] q_bytes,
  output logic [7:0] n_frames,
  output logic q_crc_ok,
  output logic [7:0] n_resp
);
  import mbrsm_pkg::*;
  logic [7:0] buf_q [0:7];
  logic [15:0] crc;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // sample each bit mid-cell, return at mid stop bit
  task automatic get_byte(output logic [7:0] b);
    while (line_i !== 1'b0) @(posedge ref_clk);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      b[i] = line_i;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask
  task automatic put_byte(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (BIT_CYC) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    line_o <= 1'b1;
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask
  initial begin
    line_o = 1'b1;
    q_bytes = '0;
    n_frames = '0;
    q_crc_ok = 1'b0;
    n_resp = '0;
    @(posedge arst_n);
    forever begin
      crc = CRC_INIT;
      for (int k = 0; k < QLEN; k++) begin
        get_byte(buf_q[k]);
        crc = crc_step(crc, buf_q[k]);
      end
      q_bytes <= {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
      n_frames <= n_frames + 8'h01;
      q_crc_ok <= (crc == 16'h0000);
      // answer only a good query for this address, never a broadcast
      if (buf_q[0] == SLV_ADDR && crc == 16'h0000) begin
        repeat (2 * BIT_CYC) @(posedge ref_clk);
        crc = crc_step(crc_step(CRC_INIT, SLV_ADDR), buf_q[1]);
        put_byte(SLV_ADDR);
        put_byte(buf_q[1]);
        put_byte(crc[7:0]);
        put_byte(crc[15:8]);
        n_resp <= n_resp + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/mbrsm_scan_master_test.sv */
// mbrsm_scan_master_test: register-level tests of the scan master.
// assumes a 50 MHz clock and one slave model on the two-wire line.
`timescale 1ns/1ps
`default_nettype none
module mbrsm_scan_master_test;
  import mbrsm_pkg::*;
  localparam int T10 = 500;
  localparam int BITC = CLK_HZ / 57600;
  logic ref_clk;
  logic arst_n;
  mbrsm_avs_req_t avs_i;
  mbrsm_avs_rsp_t avs_o;
  mbrsm_sub_in_t sub_i;
  mbrsm_sub_out_t sub_o;
  logic fatal_o;
  logic line;
  logic slv_o;
  logic [31:0] q_bytes;
  logic [7:0] n_frames;
  logic q_crc_ok;
  logic [7:0] n_resp;
  logic [31:0] rd;
  int err_count;
  int tests_run;
  int n;
  assign line = (sub_o.de485 ? sub_o.txd485 : 1'b1) & slv_o;
  assign sub_i = {2'b11, line};
  mbrsm_scan_master #(.NODES(8), .MAXB(8), .T10_CYC(T10)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .avs_i(avs_i), .avs_o(avs_o), .sub_i(sub_i), .sub_o(sub_o),
    .fatal_o(fatal_o));
  mbrsm_slave_model #(.BIT_CYC(BITC), .SLV_ADDR(8'h05), .QLEN(4)) u_slv (.ref_clk(ref_clk),
    .arst_n(arst_n), .line_i(line), .line_o(slv_o), .q_bytes(q_bytes),
    .n_frames(n_frames), .q_crc_ok(q_crc_ok), .n_resp(n_resp));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request rises after an edge, is held until waitrequest is sampled low at an edge,
  // read data is taken at that very edge, then the request is released
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_i <= '{address: a, read: !we, write: we, writedata: wd, byteenable: 4'hf};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_o.waitrequest !== 1'b0 && k < 64);
    d = avs_o.readdata;
    avs_i <= '0;
    if (avs_o.waitrequest !== 1'b0) begin
      err_count++;
      $display("mismatch waitrequest expected 0 seen 1");
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp, what);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (150000) @(posedge ref_clk);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    end_of_test();
  end
  initial begin
    arst_n = 1'b0;
    avs_i = '0;
    err_count = 0;
    tests_run = 0;
    do_reset();
    rdc(A_CTRL, 32'h0, "ctrl reset");
    rdc(A_CFG, CFG_RST, "cfg reset");
    rdc(A_TIM, TIM_RST, "tim reset");
    rdc(A_TXC, 32'h0, "txc reset");
    rdc(8'h20, 32'h0, "unmapped");
    wr(A_RXC, 32'h00000055);
    rdc(A_RXC, 32'h0, "rxc read only");
    $display("test registers done");
    // bad node, no start lock, halt on fatal
    wr(A_NODE, 32'h00001005);
    wr(A_CFG, 32'h000010ba);
    n = 0;
    while (fatal_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(fatal_o, 1'b1, "fatal_o halt");
    bus(1'b0, A_STAT, 32'h0, rd);
    chk(rd[ST_FATAL], 1'b1, "status fatal");
    chk(n_frames, 8'h00, "frames at halt");
    do_reset();
    chk(fatal_o, 1'b0, "fatal_o after reset");
    $display("test halt done");
    // control off, restart on fatal
    wr(A_NODE, 32'h00001005);
    wr(A_CFG, 32'h000010bc);
    wr(A_CTRL, 32'h00002000);
    rdc(A_CTRL, 32'h0, "ctrl unused");
    rdc(A_STAT, 32'h0, "status unused");
    repeat (2000) @(posedge ref_clk);
    chk(fatal_o, 1'b0, "fatal_o restart");
    do_reset();
    $display("test restart done");
    // start lock, one query and answer at 57600 8N1 two-wire
    wr(A_CFG, 32'h000010e9);
    wr(A_TIM, 32'h0101ff01);
    wr(A_NODE, 32'h00001105);
    wr(A_FRM, 32'h00000003);
    rdc(A_NODE, 32'h00001105, "node0");
    repeat (1000) @(posedge ref_clk);
    chk(n_frames, 8'h00, "frames before valid");
    wr(A_CTRL, 32'h00002000);
    rdc(A_CTRL, 32'h00002000, "ctrl valid");
    n = 0;
    while (n_resp !== 8'h01 && n < 100000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n_frames, 8'h01, "queries seen");
    chk(q_bytes[7:0], 8'h05, "query address");
    chk(q_bytes[15:8], 8'h03, "query byte");
    chk(q_crc_ok, 1'b1, "query crc");
    n = 0;
    rd = '0;
    while (rd !== 32'h1 && n < 400) begin
      repeat (100) @(posedge ref_clk);
      bus(1'b0, A_RXC, 32'h0, rd);
      n++;
    end
    chk(rd, 32'h1, "rx count");
    rdc(A_TXC, 32'h1, "tx count");
    rdc(A_STAT, 32'h1, "status running");
    $display("test scan done");
    end_of_test();
  end
endmodule
bind mbrsm_scan_master mbrsm_scan_checker #(.NODES(NODES), .MAXB(MAXB), .T10_CYC(T10_CYC))
  u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .avs_i(avs_i), .avs_o(avs_o), .sub_i(sub_i),
  .sub_o(sub_o), .fatal_o(fatal_o));
`default_nettype wire
